// ===== core/ur_receiver.sv
// Asynchronous serial receiver with two-entry FIFO and register port.
// Notes on behaviour
// - A character starts only on a falling line edge while idle.
// - Half a bit later the start is rechecked; a one drops it silently.
// - Each following data bit centre gets a majority sample shifted in.
// - The stop position sampled low marks the character framing-errored.
// - A finished character goes into the FIFO and raises the pending flag.
// - Reading receive data returns the oldest character and pops it.
// - Pending is high while enabled with an unread character; writes ignored.
// - Pending follows the FIFO; interrupt needs all three enables.
// - Each entry keeps its framing bit; status shows the oldest one.
// - Framing errors never block reception; popping exposes the next.
// - Framing status clears on port disable or when its entry is popped; it raises no interrupt.
// - A third complete character with both entries full sets overrun.
// - During overrun stored characters stay readable, new ones are dropped.
// - Overrun clears only by receive enable off or port disable.
// - Nine-bit mode shifts nine bits; the ninth shows in status.
// - Address detection in nine-bit mode admits only characters with the ninth bit set.
// - The receiver runs only with receive, port enable and async mode.
// - Recovery runs on the sixteen-times tick, shifting once per bit.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
module ur_receiver
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Register port.
    input wire logic [ur_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [ur_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [ur_pkg::DATA_W-1:0] reg_rdata_out,
    // Line and baud tick.
    input wire logic rx_line_in,
    input wire logic baud_tick_in,
    // Baud generator settings.
    output logic [15:0] baud_divisor_out,
    output logic high_speed_baud_select_out,
    output logic wide_baud_divisor_select_out,
    // Interrupt request.
    output logic rx_irq_out
);

    ur_pkg::ur_state_s st_q;
    ur_pkg::ur_state_s st_d;
    logic rx_en;
    logic center;
    logic maj;
    logic done;
    logic push;
    logic pop;
    logic [8:0] char_val;
    logic [3:0] last_bit;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic rx_enabled(input ur_pkg::ur_state_s s);
        rx_enabled = s.rs_ctl[ur_pkg::RS_RX_EN] & s.rs_ctl[ur_pkg::RS_PORT_EN]
            & ~s.ts_ctl[ur_pkg::TS_SYNC];
    endfunction

    function automatic logic [7:0] rd_mux(input ur_pkg::ur_state_s s, input logic [3:0] a);
        ur_pkg::ur_entry_s head;
        logic has;
        has = s.count != 2'h0;
        head = s.fifo[s.rd_ptr];
        rd_mux = 8'h00;
        case (a)
            ur_pkg::IDX_RX_STATUS_CONTROL:
            begin
                rd_mux = s.rs_ctl & ur_pkg::RS_WMASK;
                rd_mux[ur_pkg::RS_FRAME_ERR] = has & head.fe;
                rd_mux[ur_pkg::RS_OVERRUN] = s.ovr;
                rd_mux[ur_pkg::RS_NINTH] = has & head.data[8];
            end
            ur_pkg::IDX_RECEIVE_DATA:
                rd_mux = has ? head.data[7:0] : 8'h00;
            ur_pkg::IDX_TX_STATUS_CONTROL:
            begin
                rd_mux = s.ts_ctl & ur_pkg::TS_WMASK;
                // No transmitter lives here, so its shifter always reads empty.
                rd_mux[ur_pkg::TS_TRMT] = 1'b1;
            end
            ur_pkg::IDX_BAUD_CONTROL:
            begin
                rd_mux = s.bc_ctl & ur_pkg::BC_WMASK;
                rd_mux[ur_pkg::BC_RCIDL] = s.fsm == ur_pkg::RX_IDLE;
            end
            ur_pkg::IDX_BAUD_DIV_LOW:
                rd_mux = s.div_lo;
            ur_pkg::IDX_BAUD_DIV_HIGH:
                rd_mux = s.div_hi;
            ur_pkg::IDX_PERIPH_IRQ_ENABLE:
                rd_mux = s.pie;
            ur_pkg::IDX_PERIPH_IRQ_FLAGS:
                rd_mux[ur_pkg::PIR_RX_PEND] = s.pend;
            ur_pkg::IDX_IRQ_CONTROL:
                rd_mux = s.ic_ctl & ur_pkg::IC_WMASK;
            default:
                rd_mux = 8'h00;
        endcase
    endfunction

    always_comb
    begin
        st_d = st_q;
        rx_en = rx_enabled(st_q);
        last_bit = st_q.rs_ctl[ur_pkg::RS_NINE_SEL] ? ur_pkg::BITS9_LAST : ur_pkg::BITS8_LAST;
        maj = maj3(st_q.hist[1], st_q.hist[0], rx_line_in);
        center = 1'b0;
        done = 1'b0;
        push = 1'b0;
        char_val = st_q.rs_ctl[ur_pkg::RS_NINE_SEL] ? st_q.shift : {1'b0, st_q.shift[8:1]};
        pop = reg_rd_in && reg_addr_in == ur_pkg::IDX_RECEIVE_DATA
            && st_q.count != 2'h0;

        // Register writes; read-only bits are masked off.
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                ur_pkg::IDX_RX_STATUS_CONTROL:
                begin
                    st_d.rs_ctl = reg_wdata_in & ur_pkg::RS_WMASK;
                    if (!reg_wdata_in[ur_pkg::RS_RX_EN])
                    begin
                        st_d.ovr = 1'b0;
                    end
                end
                ur_pkg::IDX_TX_STATUS_CONTROL:
                    st_d.ts_ctl = reg_wdata_in & ur_pkg::TS_WMASK;
                ur_pkg::IDX_BAUD_CONTROL:
                    st_d.bc_ctl = reg_wdata_in & ur_pkg::BC_WMASK;
                ur_pkg::IDX_BAUD_DIV_LOW:
                    st_d.div_lo = reg_wdata_in;
                ur_pkg::IDX_BAUD_DIV_HIGH:
                    st_d.div_hi = reg_wdata_in;
                ur_pkg::IDX_PERIPH_IRQ_ENABLE:
                    st_d.pie = reg_wdata_in;
                ur_pkg::IDX_IRQ_CONTROL:
                    st_d.ic_ctl = reg_wdata_in & ur_pkg::IC_WMASK;
                default:
                    st_d.rdata = st_q.rdata;
            endcase
        end

        // Read data stands for exactly one cycle after the strobe.
        st_d.rdata = reg_rd_in ? rd_mux(st_q, reg_addr_in) : 8'h00;

        // Data recovery, advanced only on the oversampling tick.
        if (!rx_en)
        begin
            st_d.fsm = ur_pkg::RX_IDLE;
            st_d.tick_cnt = 4'h0;
            st_d.bit_cnt = 4'h0;
        end
        else if (baud_tick_in)
        begin
            st_d.hist = {st_q.hist[1:0], rx_line_in};
            st_d.tick_cnt = st_q.tick_cnt + 4'h1;
            case (st_q.fsm)
                ur_pkg::RX_IDLE:
                begin
                    st_d.tick_cnt = 4'h0;
                    if (st_q.hist[0] && !rx_line_in)
                    begin
                        st_d.fsm = ur_pkg::RX_START;
                    end
                end
                ur_pkg::RX_START:
                begin
                    if (st_q.tick_cnt == ur_pkg::HALF_LAST)
                    begin
                        center = 1'b1;
                        st_d.tick_cnt = 4'h0;
                        st_d.bit_cnt = 4'h0;
                        // A glitch is abandoned without any error flag.
                        st_d.fsm = maj ? ur_pkg::RX_IDLE : ur_pkg::RX_DATA;
                    end
                end
                ur_pkg::RX_DATA:
                begin
                    if (st_q.tick_cnt == ur_pkg::OSR_LAST)
                    begin
                        center = 1'b1;
                        st_d.shift = {maj, st_q.shift[8:1]};
                        st_d.bit_cnt = st_q.bit_cnt + 4'h1;
                        if (st_q.bit_cnt == last_bit)
                        begin
                            st_d.fsm = ur_pkg::RX_STOP;
                        end
                    end
                end
                ur_pkg::RX_STOP:
                begin
                    if (st_q.tick_cnt == ur_pkg::OSR_LAST)
                    begin
                        center = 1'b1;
                        done = 1'b1;
                        st_d.fsm = ur_pkg::RX_IDLE;
                    end
                end
                default:
                    st_d.fsm = ur_pkg::RX_IDLE;
            endcase
        end

        // A finished character is kept, filtered out, or turned into overrun.
        if (done && !st_q.ovr)
        begin
            if (st_q.rs_ctl[ur_pkg::RS_ADDR_DET] && st_q.rs_ctl[ur_pkg::RS_NINE_SEL]
                && !char_val[8])
            begin
                push = 1'b0;
            end
            else if (st_q.count == ur_pkg::FIFO_FULL && !pop)
            begin
                st_d.ovr = 1'b1;
            end
            else
            begin
                push = 1'b1;
            end
        end

        if (push)
        begin
            st_d.fifo[st_q.wr_ptr].data = char_val;
            st_d.fifo[st_q.wr_ptr].fe = ~maj;
            st_d.wr_ptr = ~st_q.wr_ptr;
        end
        if (pop)
        begin
            st_d.rd_ptr = ~st_q.rd_ptr;
        end
        case ({push, pop})
            2'b10:
                st_d.count = st_q.count + 2'h1;
            2'b01:
                st_d.count = st_q.count - 2'h1;
            default:
                st_d.count = st_q.count;
        endcase

        // Port disable resets the unit; framing state goes with the FIFO.
        if (!st_d.rs_ctl[ur_pkg::RS_PORT_EN])
        begin
            st_d.fsm = ur_pkg::RX_IDLE;
            st_d.count = 2'h0;
            st_d.rd_ptr = 1'b0;
            st_d.wr_ptr = 1'b0;
            st_d.ovr = 1'b0;
        end

        st_d.pend = rx_enabled(st_d) && st_d.count != 2'h0;
        // Framing errors do not enter this term, so they never interrupt.
        st_d.irq = st_d.pend && st_d.pie[ur_pkg::PIE_RX_IRQ]
            && st_d.ic_ctl[ur_pkg::IC_PERIPH] && st_d.ic_ctl[ur_pkg::IC_GLOBAL];
    end

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            st_q <= ur_pkg::ST_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_out = st_q.rdata;
    assign baud_divisor_out = {st_q.div_hi, st_q.div_lo};
    assign high_speed_baud_select_out = st_q.ts_ctl[ur_pkg::TS_HIGH_SPEED];
    assign wide_baud_divisor_select_out = st_q.bc_ctl[ur_pkg::BC_WIDE_DIV];
    assign rx_irq_out = st_q.irq;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_port_off;
        reg_wr_in && reg_addr_in == ur_pkg::IDX_RX_STATUS_CONTROL
            && !reg_wdata_in[ur_pkg::RS_PORT_EN];
    endsequence

    sequence s_unit_cleared;
        st_q.count == 2'h0 && !st_q.ovr && !st_q.pend && st_q.fsm == ur_pkg::RX_IDLE;
    endsequence

    sequence s_false_start;
        rx_en && baud_tick_in && st_q.fsm == ur_pkg::RX_START
            && st_q.tick_cnt == ur_pkg::HALF_LAST && maj;
    endsequence

    a_start_on_edge: assert property (
        st_q.fsm == ur_pkg::RX_IDLE ##1 st_q.fsm == ur_pkg::RX_START
        |-> $past(st_q.hist[0]) && !$past(rx_line_in) && $past(baud_tick_in))
        else $error("Start entered without a falling edge.");

    a_false_start_drop: assert property (
        s_false_start && !pop && !reg_wr_in |=> st_q.fsm == ur_pkg::RX_IDLE && !st_q.ovr
            && st_q.count == $past(st_q.count))
        else $error("False start not dropped silently.");

    a_pending_flag: assert property (
        st_q.pend == (rx_enabled(st_q) && st_q.count != 2'h0))
        else $error("Pending flag disagrees with FIFO.");

    a_pop_one: assert property (
        pop && !push |=> st_q.count == $past(st_q.count) - 2'h1
            && st_q.rd_ptr != $past(st_q.rd_ptr))
        else $error("Data read did not pop one entry.");

    a_overrun_set: assert property (
        done && !st_q.ovr && !st_q.rs_ctl[ur_pkg::RS_ADDR_DET]
            && st_q.count == ur_pkg::FIFO_FULL && !pop && !reg_wr_in
        |=> st_q.ovr && st_q.count == ur_pkg::FIFO_FULL)
        else $error("Third character did not set overrun.");

    a_overrun_block: assert property (
        st_q.ovr && !reg_wr_in |=> st_q.count <= $past(st_q.count))
        else $error("Character accepted during overrun.");

    a_irq_gate: assert property (
        rx_irq_out |-> st_q.pend && st_q.pie[ur_pkg::PIE_RX_IRQ]
            && st_q.ic_ctl[ur_pkg::IC_PERIPH] && st_q.ic_ctl[ur_pkg::IC_GLOBAL])
        else $error("Interrupt without all enables.");

    a_port_reset: assert property (
        s_port_off |=> s_unit_cleared)
        else $error("Port disable did not reset the unit.");

    a_frame_capture: assert property (
        push |=> $past(st_q.rs_ctl[ur_pkg::RS_PORT_EN]) |-> 1'b1 ##0
            st_q.fifo[$past(st_q.wr_ptr)].fe == !$past(maj))
        else $error("Framing bit not taken from stop sample.");

    // A stop sample in the same cycle may set overrun again; the set wins.
    a_rx_enable_clear: assert property (
        reg_wr_in && reg_addr_in == ur_pkg::IDX_RX_STATUS_CONTROL
            && !reg_wdata_in[ur_pkg::RS_RX_EN] && !done |=> !st_q.ovr)
        else $error("Receive enable off left overrun set.");

    a_addr_filter: assert property (
        done && !reg_wr_in && st_q.rs_ctl[ur_pkg::RS_ADDR_DET] && st_q.rs_ctl[ur_pkg::RS_NINE_SEL]
            && !char_val[8] |=> st_q.count == $past(st_q.count) - {1'b0, $past(pop)})
        else $error("Address filter let a data character in.");

    a_pending_raise: assert property (
        push && !reg_wr_in |=> st_q.pend)
        else $error("Stored character did not raise pending.");

    a_read_idle_zero: assert property (
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("Read data stood without a read strobe.");

    a_rx_off_keeps: assert property (
        reg_wr_in && reg_addr_in == ur_pkg::IDX_RX_STATUS_CONTROL && reg_wdata_in[ur_pkg::RS_PORT_EN]
            && !reg_wdata_in[ur_pkg::RS_RX_EN] && !done |=> st_q.count == $past(st_q.count))
        else $error("Receive enable off changed the stored characters.");

    // Sync mode has no receiver here, so recovery must park in idle.
    a_sync_parks: assert property (
        st_q.ts_ctl[ur_pkg::TS_SYNC] |=> st_q.fsm == ur_pkg::RX_IDLE)
        else $error("Receiver ran in synchronous mode.");

endmodule

// ===== dv/ur_receiver_bench.sv
// Self-checking bench for the asynchronous receiver.
`timescale 1ns/100ps
module ur_receiver_bench;
    localparam logic [3:0] A_RS = ur_pkg::IDX_RX_STATUS_CONTROL;
    localparam logic [3:0] A_RD = ur_pkg::IDX_RECEIVE_DATA;
    localparam logic [3:0] A_TS = ur_pkg::IDX_TX_STATUS_CONTROL;
    localparam logic [3:0] A_BC = ur_pkg::IDX_BAUD_CONTROL;
    localparam logic [3:0] A_PIE = ur_pkg::IDX_PERIPH_IRQ_ENABLE;
    localparam logic [3:0] A_PIR = ur_pkg::IDX_PERIPH_IRQ_FLAGS;
    localparam logic [3:0] A_IC = ur_pkg::IDX_IRQ_CONTROL;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic tick = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic line;
    logic [7:0] rdata;
    logic [15:0] div;
    logic hs;
    logic wide;
    logic irq;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;

    ur_receiver dut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .rx_line_in(line), .baud_tick_in(tick),
        .baud_divisor_out(div), .high_speed_baud_select_out(hs), .wide_baud_divisor_select_out(wide),
        .rx_irq_out(irq));
    ur_remote_tx tx (.clk_in(clk), .tick_in(tick), .line_out(line));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // A fast tick keeps frames short; one tick every four clocks.
    always @(posedge clk)
    begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled just inside it.
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic t_reset();
        rchk(A_RS, 8'h00);
        rchk(A_TS, 8'h02);
        rchk(A_RD, 8'h00);
        rchk(4'h9, 8'h00);
        rchk(A_BC, 8'h40);
        wr(A_BC + 4'h1, 8'h34);
        wr(A_BC + 4'h2, 8'h12);
        wr(A_TS, 8'h04);
        wr(A_BC, 8'h08);
        repeat (2) @(posedge clk);
        chk(div[7:0], 8'h34);
        chk(div[15:8], 8'h12);
        chk({6'h0, hs, wide}, 8'h03);
        $display("reset test done");
    endtask

    task automatic t_basic();
        wr(A_RS, 8'h90);
        wr(A_PIR, 8'h20);
        rchk(A_PIR, 8'h00);
        tx.send(9'h0a5, 1'b0, 1'b1);
        rchk(A_PIR, 8'h20);
        wr(A_PIE, 8'h20);
        wr(A_IC, 8'h40);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        wr(A_IC, 8'hc0);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        wr(A_IC, 8'h00);
        rchk(A_RD, 8'ha5);
        rchk(A_PIR, 8'h00);
        $display("basic test done");
    endtask

    task automatic t_false();
        tx.glitch();
        tx.send(9'h03c, 1'b0, 1'b1);
        rchk(A_RS, 8'h90);
        rchk(A_RD, 8'h3c);
        rchk(A_RD, 8'h00);
        $display("false start test done");
    endtask

    task automatic t_frame();
        tx.send(9'h011, 1'b0, 1'b0);
        tx.send(9'h022, 1'b0, 1'b0);
        rchk(A_RS, 8'h94);
        rchk(A_RD, 8'h11);
        rchk(A_RS, 8'h94);
        wr(A_RS, 8'h80);
        rchk(A_RS, 8'h84);
        wr(A_RS, 8'h00);
        rchk(A_RS, 8'h00);
        rchk(A_RD, 8'h00);
        $display("framing test done");
    endtask

    task automatic t_overrun();
        wr(A_RS, 8'h90);
        tx.send(9'h041, 1'b0, 1'b1);
        tx.send(9'h042, 1'b0, 1'b1);
        tx.send(9'h043, 1'b0, 1'b1);
        rchk(A_RS, 8'h92);
        tx.send(9'h044, 1'b0, 1'b1);
        rchk(A_RD, 8'h41);
        wr(A_RS, 8'h80);
        rchk(A_PIR, 8'h00);
        rchk(A_RS, 8'h80);
        wr(A_RS, 8'h90);
        rchk(A_PIR, 8'h20);
        rchk(A_RD, 8'h42);
        rchk(A_RD, 8'h00);
        tx.send(9'h045, 1'b0, 1'b1);
        rchk(A_RD, 8'h45);
        $display("overrun test done");
    endtask

    task automatic t_nine();
        wr(A_RS, 8'hd8);
        tx.send(9'h055, 1'b1, 1'b1);
        tx.send(9'h1a7, 1'b1, 1'b1);
        rchk(A_RS, 8'hd9);
        rchk(A_RD, 8'ha7);
        rchk(A_RD, 8'h00);
        wr(A_RS, 8'hd0);
        tx.send(9'h033, 1'b1, 1'b1);
        rchk(A_RS, 8'hd0);
        rchk(A_RD, 8'h33);
        $display("nine bit test done");
    endtask

    task automatic t_sync();
        wr(A_RS, 8'h90);
        wr(A_TS, 8'h14);
        tx.send(9'h05a, 1'b0, 1'b1);
        wr(A_TS, 8'h04);
        rchk(A_RD, 8'h00);
        $display("sync mode test done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_basic();
        t_false();
        t_frame();
        t_overrun();
        t_nine();
        t_sync();
        tally_and_finish();
    end
endmodule

// ===== dv/ur_remote_tx.sv
// Model of the remote serial transmitter that drives the receive line.
`timescale 1ns/100ps
module ur_remote_tx
(
    // Clock and sampling tick.
    input wire logic clk_in,
    input wire logic tick_in,
    // Serial line.
    output logic line_out
);
    initial line_out = 1'b1;

    // Timing counts whole sixteen-times ticks, so bit lengths follow the tick rate exactly.
    task automatic wait_ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_in);
            while (tick_in !== 1'b1)
                @(posedge clk_in);
        end
    endtask

    // Sends one frame, LSB first, with a chosen stop level so framing faults can be made.
    task automatic send(input logic [8:0] d, input logic nine, input logic stop_lvl);
        int n;
        n = nine ? 9 : 8;
        line_out <= 1'b0;
        wait_ticks(16);
        for (int i = 0; i < n; i++)
        begin
            line_out <= d[i];
            wait_ticks(16);
        end
        line_out <= stop_lvl;
        wait_ticks(16);
        line_out <= 1'b1;
        wait_ticks(24);
    endtask

    // A low pulse far shorter than half a bit must not be taken for a start bit.
    task automatic glitch();
        line_out <= 1'b0;
        wait_ticks(4);
        line_out <= 1'b1;
        wait_ticks(40);
    endtask
endmodule

// ===== inc/ur_pkg.sv
// Constants and types shared by the asynchronous receiver.
package ur_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register indices on the plain register port.
    localparam logic [3:0] IDX_RX_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] IDX_RECEIVE_DATA = 4'h1;
    localparam logic [3:0] IDX_TX_STATUS_CONTROL = 4'h2;
    localparam logic [3:0] IDX_BAUD_CONTROL = 4'h3;
    localparam logic [3:0] IDX_BAUD_DIV_LOW = 4'h4;
    localparam logic [3:0] IDX_BAUD_DIV_HIGH = 4'h5;
    localparam logic [3:0] IDX_PERIPH_IRQ_ENABLE = 4'h6;
    localparam logic [3:0] IDX_PERIPH_IRQ_FLAGS = 4'h7;
    localparam logic [3:0] IDX_IRQ_CONTROL = 4'h8;
    // Field positions.
    localparam int RS_PORT_EN = 7;
    localparam int RS_NINE_SEL = 6;
    localparam int RS_RX_EN = 4;
    localparam int RS_ADDR_DET = 3;
    localparam int RS_FRAME_ERR = 2;
    localparam int RS_OVERRUN = 1;
    localparam int RS_NINTH = 0;
    localparam int TS_SYNC = 4;
    localparam int TS_HIGH_SPEED = 2;
    localparam int TS_TRMT = 1;
    localparam int BC_RCIDL = 6;
    localparam int BC_WIDE_DIV = 3;
    localparam int PIE_RX_IRQ = 5;
    localparam int PIR_RX_PEND = 5;
    localparam int IC_GLOBAL = 7;
    localparam int IC_PERIPH = 6;
    // Writable bits of the mixed registers.
    localparam logic [7:0] RS_WMASK = 8'hf8;
    localparam logic [7:0] TS_WMASK = 8'hfd;
    localparam logic [7:0] BC_WMASK = 8'h1b;
    localparam logic [7:0] IC_WMASK = 8'hc0;
    // Oversampling and framing.
    localparam logic [3:0] OSR_LAST = 4'hf;
    localparam logic [3:0] HALF_LAST = 4'h7;
    localparam logic [3:0] BITS8_LAST = 4'h7;
    localparam logic [3:0] BITS9_LAST = 4'h8;
    localparam logic [1:0] FIFO_FULL = 2'h2;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ur_rx_e;

    typedef struct packed {
        logic fe;
        logic [8:0] data;
    } ur_entry_s;

    typedef struct packed {
        ur_rx_e fsm;
        logic [3:0] tick_cnt;
        logic [3:0] bit_cnt;
        logic [2:0] hist;
        logic [8:0] shift;
        ur_entry_s [1:0] fifo;
        logic rd_ptr;
        logic wr_ptr;
        logic [1:0] count;
        logic ovr;
        logic pend;
        logic irq;
        logic [7:0] rs_ctl;
        logic [7:0] ts_ctl;
        logic [7:0] bc_ctl;
        logic [7:0] pie;
        logic [7:0] ic_ctl;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] rdata;
    } ur_state_s;

    localparam ur_state_s ST_RESET = '0;
endpackage
